// *** core/dxmr_cmd_decode.v ***
/*
 * Command decoder for the device pins: recognises a configuration
 * register set command and flags a refresh configuration or first extended register select.
 * Assumes command pins already sampled on mclk.
 */
module dxmr_cmd_decode (
    cke_prev,
    cke,
    cs_n,
    ras_n,
    cas_n,
    we_n,
    ba,
    is_first_ext,
    is_refresh_cfg,
    is_any_mrs
);
`include "dxmr_defs.vh"
    input wire cke_prev;
    input wire cke;
    input wire cs_n;
    input wire ras_n;
    input wire cas_n;
    input wire we_n;
    input wire [1:0] ba;
    output wire is_first_ext;
    output wire is_refresh_cfg;
    output wire is_any_mrs;

    // ------------------------------------------------------------
    // Set command: all four strobes low, clock enable high twice
    // ------------------------------------------------------------
    assign is_any_mrs = cke_prev & cke & ~cs_n & ~ras_n & ~cas_n & ~we_n; // R6
    assign is_refresh_cfg = is_any_mrs & (ba == `DXMR_BA_REFRESH_CFG); // R6
    assign is_first_ext = is_any_mrs & (ba == `DXMR_BA_FIRST_EXT); // R15
endmodule // dxmr_cmd_decode

// *** core/dxmr_top.v ***
/*
 * Extended configuration register load logic of the memory device:
 * the refresh configuration register and the output-disable and
 * strobe-control part of the first extended register, with an
 * AXI4-Lite window for control and observation.
 * Assumes command pins synchronous to mclk; one clock domain.
 */
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
// Behaviour
// R1 - The wide organisation has no read-strobe copy, so the controller writes zero there.
// R2 - A calibration adjust write keeps the posted read delay already programmed.
// R3 - After the calibration default, calibration is left by writing zero to its field.
// R4 - With the output-off bit set, data, strobe and read-strobe outputs are all disabled.
// R5 - The refresh configuration has no power-up value and must be programmed at init.
// R6 - The refresh configuration is loaded from A0-A12 on a set command with BA1 high, BA0 low.
// R7 - All banks precharged and clock enable already high before that write.
// R8 - The controller waits the mode-set cycle gap after the write.
// R9 - Rewrites in normal operation are accepted while all banks are precharged.
// R10 - Bit seven enables the high-temperature self-refresh rate.
// R11 - That faster rate exists only on extended-temperature grades.
// R12 - Bits two to zero choose full, half, quarter or three-quarter array refresh.
// R13 - Reserved bits of the refresh configuration are written as zero.
// R14 - Outside the chosen region data is lost once self-refresh is entered.
// R15 - The first extended register uses the same command with BA0 high, BA1 low.
// R16 - The controller never loads the undefined or reserved partial codes.
// R17 - Bank address bits are not stored, only the defined address fields; the code stores all of A0-A12 in both registers.
module dxmr_top (
    mclk,
    rst,
    cke,
    cs_n,
    ras_n,
    cas_n,
    we_n,
    ba,
    addr,
    banks_precharged,
    self_refresh,
    high_temp_refresh_rate,
    partial_self_refresh,
    bank_refresh_en,
    dq_out_en,
    dqs_out_en,
    read_strobe_copy_en,
    rcr_loaded,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready
);
`include "dxmr_defs.vh"
    input wire mclk;
    input wire rst;
    input wire cke;
    input wire cs_n;
    input wire ras_n;
    input wire cas_n;
    input wire we_n;
    input wire [1:0] ba;
    input wire [12:0] addr;
    input wire banks_precharged;
    input wire self_refresh;
    output reg high_temp_refresh_rate;
    output reg [2:0] partial_self_refresh;
    output reg [3:0] bank_refresh_en;
    output reg dq_out_en;
    output reg dqs_out_en;
    output reg read_strobe_copy_en;
    output reg rcr_loaded;
    input wire [3:0] s_axi_awaddr;
    input wire s_axi_awvalid;
    output reg s_axi_awready;
    input wire [31:0] s_axi_wdata;
    input wire [3:0] s_axi_wstrb;
    input wire s_axi_wvalid;
    output reg s_axi_wready;
    output reg [1:0] s_axi_bresp;
    output reg s_axi_bvalid;
    input wire s_axi_bready;
    input wire [3:0] s_axi_araddr;
    input wire s_axi_arvalid;
    output reg s_axi_arready;
    output reg [31:0] s_axi_rdata;
    output reg [1:0] s_axi_rresp;
    output reg s_axi_rvalid;
    input wire s_axi_rready;

    // ------------------------------------------------------------
    // Decode helper
    // ------------------------------------------------------------
    // Bank refresh enables for a partial code; unknown codes refresh
    // everything, which costs power but never loses data.
    function [3:0] psr_banks;
        input [2:0] code;
        begin
            case (code)
                `DXMR_PSR_FULL: psr_banks = 4'hF;
                `DXMR_PSR_HALF: psr_banks = 4'h3;
                `DXMR_PSR_QUARTER: psr_banks = 4'h1;
                `DXMR_PSR_THREEQ: psr_banks = 4'h7;
                default: psr_banks = 4'hF;
            endcase
        end
    endfunction

    reg cke_prev_r;
    reg [12:0] rcr_r;
    reg [12:0] fecr_r;
    reg [1:0] ctrl_r;
    // Load counter and bus-side holding state
    reg [7:0] mrs_count_r;
    reg aw_have_r;
    reg w_have_r;
    reg [3:0] aw_off_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    wire is_first_ext;
    wire is_refresh_cfg;
    wire rcr_take;
    wire fecr_take;
    wire wr_fire;
    wire ext_temp;
    wire wide_org;
    wire out_off;
    wire [12:0] rcr_mask;
    wire [12:0] rcr_view;

    // Only the two selected loads matter here, so the any-set flag is left open
    dxmr_cmd_decode u_dec (
        .cke_prev(cke_prev_r),
        .cke(cke),
        .cs_n(cs_n),
        .ras_n(ras_n),
        .cas_n(cas_n),
        .we_n(we_n),
        .ba(ba),
        .is_first_ext(is_first_ext),
        .is_refresh_cfg(is_refresh_cfg),
        .is_any_mrs()
    );

    // ------------------------------------------------------------
    // Command capture
    // ------------------------------------------------------------
    // A load is taken only with all banks precharged, at power-up
    // sequence or in normal operation alike.
    assign rcr_take = is_refresh_cfg & banks_precharged; // R9
    assign fecr_take = is_first_ext & banks_precharged; // R9
    assign wide_org = ctrl_r[`DXMR_CTRL_WIDE_BIT];
    assign ext_temp = ctrl_r[`DXMR_CTRL_EXTTEMP_BIT];
    // Reserved bits and, on commercial grade, the rate bit are dropped
    assign rcr_mask = ~(`DXMR_RCR_RESERVED_MASK |
                        (ext_temp ? 13'h0000 : 13'h0080)); // R11
    assign rcr_view = rcr_r & rcr_mask;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cke_prev_r <= 1'b0;
            rcr_r <= `DXMR_RCR_RESET;
            fecr_r <= `DXMR_FECR_RESET;
            rcr_loaded <= 1'b0;
            mrs_count_r <= 8'h00;
        end else begin
            cke_prev_r <= cke;
            if (rcr_take) begin
                rcr_r <= addr; // R6 R17
                rcr_loaded <= 1'b1;
            end
            if (fecr_take) begin
                fecr_r <= addr; // R15 R17
            end
            if (rcr_take | fecr_take) begin
                mrs_count_r <= mrs_count_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Refresh and output controls, all registered
    // ------------------------------------------------------------
    // The read-strobe copy is forced off on the wide organisation so
    // a stray bit cannot enable a pin that does not exist.
    assign out_off = fecr_r[`DXMR_OUTOFF_BIT];
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            high_temp_refresh_rate <= 1'b0;
            partial_self_refresh <= `DXMR_PSR_FULL;
            bank_refresh_en <= 4'hF;
            dq_out_en <= 1'b0;
            dqs_out_en <= 1'b0;
            read_strobe_copy_en <= 1'b0;
        end else begin
            high_temp_refresh_rate <= rcr_view[`DXMR_HTR_BIT]; // R10 R11
            partial_self_refresh <= rcr_view[`DXMR_PSR_MSB:`DXMR_PSR_LSB]; // R12
            // Partial refresh applies only in self-refresh
            bank_refresh_en <= self_refresh ?
                psr_banks(rcr_view[`DXMR_PSR_MSB:`DXMR_PSR_LSB]) : 4'hF; // R12 R14
            dq_out_en <= ~out_off; // R4
            dqs_out_en <= ~out_off; // R4
            read_strobe_copy_en <= ~out_off & fecr_r[`DXMR_RSC_BIT] & ~wide_org; // R4 R1
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_off_r <= 4'h0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DXMR_AXI_OKAY;
            ctrl_r <= `DXMR_CTRL_RESET;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_off_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Only the control word is writable; pin-loaded registers
                // stay under the memory controller's command alone
                if (aw_off_r == `DXMR_OFF_CTRL) begin
                    s_axi_bresp <= `DXMR_AXI_OKAY;
                    if (w_strb_r[0]) begin
                        ctrl_r <= w_data_r[1:0];
                    end
                end else if (aw_off_r == `DXMR_OFF_RCR || aw_off_r == `DXMR_OFF_FECR ||
                             aw_off_r == `DXMR_OFF_STAT) begin
                    s_axi_bresp <= `DXMR_AXI_OKAY;
                end else begin
                    s_axi_bresp <= `DXMR_AXI_SLVERR;
                end
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DXMR_AXI_OKAY;
        end else begin
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `DXMR_AXI_OKAY;
                case (s_axi_araddr)
                    `DXMR_OFF_CTRL: s_axi_rdata <= {30'h00000000, ctrl_r};
                    `DXMR_OFF_RCR: s_axi_rdata <= {19'h00000, rcr_view};
                    `DXMR_OFF_FECR: s_axi_rdata <= {19'h00000, fecr_r};
                    `DXMR_OFF_STAT: s_axi_rdata <= {22'h000000, mrs_count_r,
                                                    self_refresh, rcr_loaded};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `DXMR_AXI_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // dxmr_top

// *** inc/dxmr_defs.vh ***
/*
 * Constants for the extended configuration register load logic:
 * command decode, field positions, encodings and bus offsets.
 * Assumes inclusion by bare name from the core design files.
 */
`ifndef DXMR_DEFS_VH
`define DXMR_DEFS_VH

// ----------------------------------------------------------------
// Register select on the bank address pins
// ----------------------------------------------------------------
`define DXMR_BA_MODE 2'h0
`define DXMR_BA_FIRST_EXT 2'h1
`define DXMR_BA_REFRESH_CFG 2'h2
`define DXMR_BA_THIRD_EXT 2'h3

// ----------------------------------------------------------------
// Refresh configuration register fields
// ----------------------------------------------------------------
`define DXMR_HTR_BIT 7
`define DXMR_PSR_MSB 2
`define DXMR_PSR_LSB 0
`define DXMR_RCR_RESERVED_MASK 13'h1F78
`define DXMR_RCR_RESET 13'h0000

// Partial self-refresh codes
`define DXMR_PSR_FULL 3'h0
`define DXMR_PSR_HALF 3'h1
`define DXMR_PSR_QUARTER 3'h2
`define DXMR_PSR_UNDEF 3'h3
`define DXMR_PSR_THREEQ 3'h4

// ----------------------------------------------------------------
// First extended configuration register fields
// ----------------------------------------------------------------
`define DXMR_OUTOFF_BIT 12
`define DXMR_RSC_BIT 11
`define DXMR_DCAL_MSB 9
`define DXMR_DCAL_LSB 7
`define DXMR_PRD_MSB 5
`define DXMR_PRD_LSB 3
`define DXMR_DCAL_EXIT 3'h0
`define DXMR_DCAL_ADJUST 3'h4
`define DXMR_DCAL_DEFAULT 3'h7
`define DXMR_FECR_RESET 13'h0000

// ----------------------------------------------------------------
// Bus register offsets (byte addresses)
// ----------------------------------------------------------------
`define DXMR_OFF_CTRL 4'h0
`define DXMR_OFF_RCR 4'h4
`define DXMR_OFF_FECR 4'h8
`define DXMR_OFF_STAT 4'hC
`define DXMR_AXI_OKAY 2'h0
`define DXMR_AXI_SLVERR 2'h2

// Control register bits
`define DXMR_CTRL_WIDE_BIT 0
`define DXMR_CTRL_EXTTEMP_BIT 1
`define DXMR_CTRL_RESET 2'h0

`endif

// *** tb/dxmr_ctrl_model.sv ***
/*
 * Memory controller model: drives set commands on the command pins.
 * Assumes mclk from the bench and one load at a time.
 */
module dxmr_ctrl_model (
    input wire logic mclk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [12:0] addr
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Command driver
    // ------------------------------------------------------------
    parameter int GAP = 2; // Mode-set cycle gap in clocks
    // Clock enable stays high so every load sees it high beforehand
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        ba = 2'h0;
        addr = 13'h0000;
    end
    // One set command, then deselect and honour the gap
    task automatic load(input logic [1:0] b, input logic [12:0] a);
        @(posedge mclk);
        {cs_n, ras_n, cas_n, we_n} <= 4'h0;
        ba <= b;
        addr <= a;
        @(posedge mclk);
        {cs_n, ras_n, cas_n, we_n} <= 4'hF;
        ba <= ~b; // Released lines show the inverse, never a stale value
        addr <= ~a;
        repeat (GAP) @(posedge mclk);
    endtask
endmodule // dxmr_ctrl_model

// *** tb/dxmr_properties.sv ***
/*
 * Property checker for the configuration register load logic.
 * Assumes it is bound to the top module and sees only its ports.
 */
module dxmr_properties (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    input wire logic banks_precharged,
    input wire logic self_refresh,
    input wire logic [2:0] partial_self_refresh,
    input wire logic [3:0] bank_refresh_en,
    input wire logic dq_out_en,
    input wire logic dqs_out_en,
    input wire logic read_strobe_copy_en,
    input wire logic rcr_loaded,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    // ------------------------------------------------------------
    // Command decode from the pins alone
    // ------------------------------------------------------------
    wire mrs = cke && !cs_n && !ras_n && !cas_n && !we_n;
    wire ok = mrs && banks_precharged;
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (rst);
    // Accepted refresh configuration load; cke must also be high before
    sequence ld_rcr;
        $past(cke) && ok && ba == 2'h2;
    endsequence
    a_psr_follows: assert property (
        ld_rcr |-> ##2 partial_self_refresh == $past(addr[2:0], 2))
        else $error("partial field does not follow the load");
    a_load_flag: assert property (ld_rcr |=> rcr_loaded)
        else $error("loaded flag missing after load");
    a_flag_sticky: assert property (rcr_loaded |=> rcr_loaded)
        else $error("loaded flag dropped");
    a_refused_hold: assert property (
        (mrs && !banks_precharged && ba == 2'h2) ##1 !ok |=> $stable(partial_self_refresh))
        else $error("load taken with banks open");
    a_awake_all: assert property (!self_refresh |=> bank_refresh_en == 4'hF)
        else $error("banks not all refreshed while awake");
    a_half_map: assert property (
        $past(self_refresh) && partial_self_refresh == 3'h1 |-> bank_refresh_en == 4'h3)
        else $error("half array maps to wrong banks");
    a_out_off: assert property (
        ($past(cke) && ok && ba == 2'h1 && addr[12])
        |-> ##2 !(dq_out_en || dqs_out_en || read_strobe_copy_en))
        else $error("outputs still enabled after output off");
    a_strobe_pair: assert property (read_strobe_copy_en |-> dq_out_en && dqs_out_en)
        else $error("read strobe on while outputs off");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not presented");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn");
    // Main scenarios reached
    c_load: cover property (ld_rcr);
    c_refused: cover property (mrs && !banks_precharged);
    c_threeq: cover property (self_refresh && partial_self_refresh == 3'h4);
endmodule // dxmr_properties

bind dxmr_top dxmr_properties u_props (.mclk(mclk), .rst(rst), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .banks_precharged(banks_precharged), .self_refresh(self_refresh),
    .partial_self_refresh(partial_self_refresh), .bank_refresh_en(bank_refresh_en),
    .dq_out_en(dq_out_en), .dqs_out_en(dqs_out_en), .read_strobe_copy_en(read_strobe_copy_en),
    .rcr_loaded(rcr_loaded), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for the configuration register load logic.
 * Assumes the controller model and the bound property checker.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic bp = 1'b1;
    logic sr = 1'b0;
    logic cke, cs_n, ras_n, cas_n, we_n, htr, dqe, dse, rse, ldd;
    logic [1:0] ba, bresp, rresp, r;
    logic [12:0] addr;
    logic [2:0] psr;
    logic [3:0] bre, awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata, rd;
    int mismatches = 0;
    int tests_run = 0;
    // 40 MHz clock
    always #12.5 mclk = ~mclk;
    dxmr_ctrl_model u_ctrl (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
    dxmr_top u_dut (.mclk(mclk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .banks_precharged(bp),
        .self_refresh(sr), .high_temp_refresh_rate(htr), .partial_self_refresh(psr),
        .bank_refresh_en(bre), .dq_out_en(dqe), .dqs_out_en(dse), .read_strobe_copy_en(rse),
        .rcr_loaded(ldd), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task report_and_stop;
        $display("compared %0d, unexpected %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // A wait that ran out counts against the run and ends it
    task give_up;
        mismatches++;
        report_and_stop();
    endtask
    // Address and data offered together, each dropped when taken
    task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 50 && bvalid !== 1'b1; n++) begin
            @(posedge mclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end
        if (bvalid !== 1'b1) give_up();
        resp = bresp;
        bready <= 1'b0;
    endtask
    task axi_rd(input logic [3:0] a, output logic [31:0] d);
        int n;
        @(posedge mclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 50 && rvalid !== 1'b1; n++) begin
            @(posedge mclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end
        if (rvalid !== 1'b1) give_up();
        d = rdata;
        rready <= 1'b0;
    endtask
    // Load, then one more edge so the outputs have settled
    task ld(input logic [1:0] b, input logic [12:0] a);
        u_ctrl.load(b, a);
        @(posedge mclk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        chk(bre, 4'hF);
        chk(ldd, 1'b0);
        chk({dqe, dse}, 2'h3);
        $display("test reset done");
    endtask
    task t_rate;
        ld(2'h2, 13'h0081);
        chk({htr, psr, ldd}, 5'h03);
        axi_wr(4'h0, 32'h2, r);
        chk(r, 2'h0);
        ld(2'h2, 13'h0081);
        chk(htr, 1'b1);
        axi_rd(4'h4, rd);
        chk(rd, 32'h81);
        $display("test rate done");
    endtask
    task t_reserved;
        ld(2'h2, 13'h0004);
        axi_rd(4'h4, rd);
        chk(rd, 32'h4);
        ld(2'h0, 13'h0001);
        ld(2'h3, 13'h0002);
        chk(psr, 3'h4);
        $display("test reserved done");
    endtask
    // Undefined code is never issued by the controller
    task t_map;
        static logic [2:0] c [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        static logic [3:0] m [4] = '{4'hF, 4'h3, 4'h1, 4'h7};
        for (int i = 0; i < 4; i++) begin
            ld(2'h2, {10'h000, c[i]});
            sr <= 1'b1;
            repeat (2) @(posedge mclk);
            chk(bre, m[i]);
            sr <= 1'b0;
        end
        $display("test map done");
    endtask
    task t_refused;
        bp <= 1'b0;
        ld(2'h2, 13'h0002);
        chk(psr, 3'h4);
        bp <= 1'b1;
        ld(2'h2, 13'h0002);
        chk(psr, 3'h2);
        $display("test refused done");
    endtask
    task t_first_ext;
        ld(2'h1, 13'h1000);
        chk({dqe, dse, rse, psr}, 6'h02);
        ld(2'h1, 13'h0800);
        chk({dqe, dse, rse}, 3'h7);
        axi_wr(4'h0, 32'h3, r);
        chk(r, 2'h0);
        ld(2'h1, 13'h0000);
        chk({dqe, dse, rse}, 3'h6);
        // Calibration default, adjust with the delay kept, then exit
        ld(2'h1, 13'h0398);
        ld(2'h1, 13'h0218);
        ld(2'h1, 13'h0018);
        axi_rd(4'h8, rd);
        chk(rd, 32'h18);
        $display("test first ext done");
    endtask
    task t_bus;
        axi_wr(4'h4, 32'h7, r);
        chk(r, 2'h0);
        axi_rd(4'h4, rd);
        chk(rd, 32'h2);
        axi_wr(4'h2, 32'h0, r);
        chk(r, 2'h2);
        axi_rd(4'hC, rd);
        chk(rd[1:0], 2'h1);
        chk(rresp, 2'h0);
        axi_rd(4'h6, rd);
        chk(rresp, 2'h2);
        chk(rd, 32'h0);
        $display("test bus done");
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        t_reset();
        t_rate();
        t_reserved();
        t_map();
        t_refused();
        t_first_ext();
        t_bus();
        report_and_stop();
    end
endmodule // tb_top
